// ==== logic/drs_pkg.sv ====
`default_nettype none
package drs_pkg;
  // System clock period and the refresh interval, in nanoseconds.
  localparam int CLK_PERIOD_NS = 10;
  localparam int REFRESH_PERIOD_NS = 9600;
  // Refresh interval in clock cycles; the interval is a period, so it is rounded down.
  localparam int REFRESH_CYCLES = REFRESH_PERIOD_NS / CLK_PERIOD_NS;
  localparam int REF_TIMER_W = 10;
  localparam logic [REF_TIMER_W-1:0] REF_TIMER_LAST = REF_TIMER_W'(REFRESH_CYCLES - 1);
  localparam logic [REF_TIMER_W-1:0] REF_TIMER_RST = 10'h000;

  // Positions of the 4-bit sequence counter inside each sequence.
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [3:0] PRECHG_LAST = 4'h1;
  localparam logic [3:0] RD_WORD0 = 4'h2;
  localparam logic [3:0] RF_ACK = 4'h5;
  localparam logic [3:0] RF_LAST = 4'h8;
  localparam logic [3:0] WR_ACK = 4'h1;
  localparam logic [3:0] WR_CAS = 4'h3;
  localparam logic [3:0] PW_ACK = 4'h0;
  localparam logic [3:0] PW_CAS = 4'h1;
  localparam logic [3:0] REF_CAS_ON = 4'h2;
  localparam logic [3:0] REF_CAS_OFF = 4'h6;
  localparam logic [3:0] REF_RAS_ON = 4'h3;
  localparam logic [3:0] REF_RAS_OFF = 4'h7;
  localparam logic [3:0] REF_LAST = 4'h9;

  // Cycles during which bus requests are ignored after an access ends.
  localparam logic [1:0] BUS_BLANK = 2'h2;
  localparam logic [1:0] BLANK_RST = 2'h0;

  // Read data path and its buffer.
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_CNT_W = 6;
  // A read starts only while the buffer has room for four words and one in flight.
  localparam logic [FIFO_CNT_W-1:0] FIFO_START_MAX = 6'h1B;

  // Synchronised request bits: rd, wr, burst, space bit, near hint, bank (2).
  localparam int REQ_W = 7;
  localparam logic [REQ_W-1:0] REQ_RST = 7'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    DRS_IDLE,
    DRS_IDLE_RAS,
    DRS_PRECHG,
    DRS_READ,
    DRS_REFILL,
    DRS_WRITE,
    DRS_PWRITE,
    DRS_REFRESH
  } drs_state_t;
endpackage
`default_nettype wire

// ==== logic/drs_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module drs_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 32,
  parameter int CW = 6
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data,
  output logic [CW-1:0] o_count
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign o_ready = (count_r != CNT_FULL);
  assign o_valid = (count_r != '0);
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_data = mem_r[rd_ptr_r];
  assign o_count = count_r;

  // Storage is written only on an accepted push.
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_data;
    end
  end

  // Pointers wrap at the configured depth.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
      end
    end
  end

  // Occupancy tracks simultaneous push and pop.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      count_r <= '0;
    end else if (push && !pop) begin
      count_r <= count_r + 1'b1;
    end else if (pop && !push) begin
      count_r <= count_r - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== logic/drs_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module drs_sequencer
  import drs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic i_burst,
  input wire logic i_dram_space_select_bit,
  input wire logic i_near_write_hint,
  input wire logic [1:0] i_bank_sel,
  input wire logic [DATA_W-1:0] i_dram_data,
  input wire logic i_cpu_ready,
  output logic o_cpu_valid,
  output logic [DATA_W-1:0] o_cpu_data,
  output logic o_cycle_in_progress,
  output logic o_mem_ack,
  output logic o_read_data_enable_out,
  output logic o_data_latch_enable,
  output logic [3:0] o_ras,
  output logic [3:0] o_cas,
  output logic o_page_open_flag,
  output logic o_refresh_ack,
  output logic o_reset_in_progress
);
  drs_state_t state_r;
  drs_state_t state_nxt;
  drs_state_t pend_r;
  logic [3:0] cnt_r;
  logic count_gate;
  logic [REQ_W-1:0] req_s1_r;
  logic [REQ_W-1:0] req_s2_r;
  logic [DATA_W-1:0] data_s1_r;
  logic [DATA_W-1:0] data_s2_r;
  logic le_d1_r;
  logic le_d2_r;
  logic [1:0] bank_r;
  logic [1:0] blank_r;
  logic page_open_r;
  logic ref_ack_r;
  logic rip_r;
  logic [REF_TIMER_W-1:0] ref_timer_r;
  logic ref_pulse;
  logic rd;
  logic wr;
  logic burst;
  logic space_hi;
  logic near;
  logic fifo_room;
  logic fifo_ready;
  logic [FIFO_CNT_W-1:0] fifo_count;
  logic seq_end;
  logic refill_word;

  // Bus pins come from the processor's pads, so each passes two flops first.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      req_s1_r <= REQ_RST;
      req_s2_r <= REQ_RST;
    end else begin
      req_s1_r <= {i_rd, i_wr, i_burst, i_dram_space_select_bit, i_near_write_hint, i_bank_sel};
      req_s2_r <= req_s1_r;
    end
  end

  assign rd = req_s2_r[6];
  assign wr = req_s2_r[5];
  assign burst = req_s2_r[4];
  assign space_hi = req_s2_r[3];
  assign near = req_s2_r[2];

  // Read data is synchronised the same way; the latch strobe is delayed to match.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      data_s1_r <= DATA_RST;
      data_s2_r <= DATA_RST;
      le_d1_r <= 1'b0;
      le_d2_r <= 1'b0;
    end else begin
      data_s1_r <= i_dram_data;
      data_s2_r <= data_s1_r;
      le_d1_r <= o_data_latch_enable;
      le_d2_r <= le_d1_r;
    end
  end

  // A read is not started unless the buffer can absorb every word it brings.
  assign fifo_room = (fifo_count <= FIFO_START_MAX);

  drs_fifo #(
    .W(DATA_W),
    .DEPTH(FIFO_DEPTH),
    .CW(FIFO_CNT_W)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_valid(le_d2_r),
    .o_ready(fifo_ready),
    .i_data(data_s2_r),
    .o_valid(o_cpu_valid),
    .i_ready(i_cpu_ready),
    .o_data(o_cpu_data),
    .o_count(fifo_count)
  );

  // Refresh timer; it is held at zero while a refresh is owed or reset is in progress.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ref_timer_r <= REF_TIMER_RST;
    end else if (ref_ack_r || rip_r) begin
      ref_timer_r <= REF_TIMER_RST;
    end else if (ref_pulse) begin
      ref_timer_r <= REF_TIMER_RST;
    end else begin
      ref_timer_r <= ref_timer_r + 1'b1;
    end
  end

  assign ref_pulse = (ref_timer_r == REF_TIMER_LAST) && !ref_ack_r && !rip_r;

  // Word strobes of a refill fall on every even count from the first word on.
  assign refill_word = (cnt_r >= RD_WORD0) && (cnt_r <= RF_LAST) && !cnt_r[0];

  // Last cycle of each timed sequence.
  always_comb begin
    case (state_r)
      DRS_READ: seq_end = (cnt_r == RD_WORD0);
      DRS_REFILL: seq_end = (cnt_r == RF_LAST);
      DRS_WRITE: seq_end = (cnt_r == WR_CAS);
      DRS_PWRITE: seq_end = (cnt_r == PW_CAS);
      DRS_REFRESH: seq_end = (cnt_r == REF_LAST);
      DRS_PRECHG: seq_end = (cnt_r == PRECHG_LAST);
      default: seq_end = 1'b0;
    endcase
  end

  // Next state; an owed refresh beats any bus request once the bus is free.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DRS_IDLE: begin
        if (rip_r || ref_ack_r) begin
          state_nxt = DRS_REFRESH;
        end else if (blank_r == BLANK_RST && !space_hi) begin
          if (rd && fifo_room) begin
            state_nxt = burst ? DRS_REFILL : DRS_READ;
          end else if (wr) begin
            state_nxt = DRS_WRITE;
          end
        end
      end
      DRS_IDLE_RAS: begin
        if (ref_ack_r) begin
          state_nxt = DRS_REFRESH;
        end else if (blank_r == BLANK_RST && (rd || wr)) begin
          if (space_hi) begin
            state_nxt = DRS_IDLE;
          end else if (wr && near) begin
            state_nxt = DRS_PWRITE;
          end else if (wr || fifo_room) begin
            state_nxt = DRS_PRECHG;
          end
        end
      end
      DRS_PRECHG: begin
        if (seq_end) begin
          state_nxt = pend_r;
        end
      end
      DRS_WRITE, DRS_PWRITE: begin
        if (seq_end) begin
          state_nxt = DRS_IDLE_RAS;
        end
      end
      DRS_READ, DRS_REFILL, DRS_REFRESH: begin
        if (seq_end) begin
          state_nxt = DRS_IDLE;
        end
      end
      default: state_nxt = DRS_IDLE;
    endcase
  end

  // State register; reset forces the idle state.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_r <= DRS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // The access type behind a precharge is held until the precharge completes.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pend_r <= DRS_READ;
    end else if (state_r == DRS_IDLE_RAS && state_nxt == DRS_PRECHG) begin
      pend_r <= wr ? DRS_WRITE : (burst ? DRS_REFILL : DRS_READ);
    end
  end

  // Row bank is captured while idle or as a held row is given up for precharge.
  // A held row must never wander to another bank while its strobe stays asserted.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      bank_r <= 2'h0;
    end else if (state_r == DRS_IDLE || state_nxt == DRS_PRECHG) begin
      bank_r <= req_s2_r[1:0];
    end
  end

  // Sequence counter runs only inside a sequence and restarts on every entry.
  assign count_gate = (state_nxt == state_r) && (state_r != DRS_IDLE)
                      && (state_r != DRS_IDLE_RAS);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= CNT_RST;
    end else if (count_gate) begin
      cnt_r <= cnt_r + 1'b1;
    end else begin
      cnt_r <= CNT_RST;
    end
  end

  // Synchronised request lines lag the processor by two cycles, so a request
  // still visible just after an access ended must not start a second one.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      blank_r <= BLANK_RST;
    end else if (seq_end && state_r != DRS_PRECHG) begin
      blank_r <= BUS_BLANK;
    end else if (blank_r != BLANK_RST) begin
      blank_r <= blank_r - 1'b1;
    end
  end

  // Page flag: set by a finished write, kept through precharge, cleared when
  // the delayed read or a refresh ends, or an outside access closes the row.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      page_open_r <= 1'b0;
    end else if (state_nxt == DRS_IDLE) begin
      page_open_r <= 1'b0;
    end else if (state_nxt == DRS_IDLE_RAS) begin
      page_open_r <= 1'b1;
    end
  end

  // Refresh acknowledge rises on the edge after the request and holds until
  // the refresh is done; a new request cannot collide since the timer is halted.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ref_ack_r <= 1'b0;
    end else if (ref_pulse) begin
      ref_ack_r <= 1'b1;
    end else if (state_r == DRS_REFRESH && seq_end) begin
      ref_ack_r <= 1'b0;
    end
  end

  // Reset flag is raised by reset itself and dropped after the first refresh.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rip_r <= 1'b1;
    end else if (state_r == DRS_REFRESH && seq_end) begin
      rip_r <= 1'b0;
    end
  end

  // Strobe decode from state and count; a precharge shows no row strobe at all.
  always_comb begin
    o_cycle_in_progress = 1'b0;
    o_mem_ack = 1'b0;
    o_read_data_enable_out = 1'b0;
    o_data_latch_enable = 1'b0;
    o_ras = 4'h0;
    o_cas = 4'h0;
    case (state_r)
      DRS_IDLE: o_ras = 4'h0;
      DRS_IDLE_RAS: o_ras = 4'h1 << bank_r;
      DRS_PRECHG: o_cycle_in_progress = 1'b1;
      DRS_READ: begin
        o_cycle_in_progress = 1'b1;
        o_ras = 4'h1 << bank_r;
        if (cnt_r == RD_WORD0) begin
          o_cas = 4'hF;
          o_read_data_enable_out = 1'b1;
          o_data_latch_enable = 1'b1;
          o_mem_ack = 1'b1;
        end
      end
      DRS_REFILL: begin
        o_cycle_in_progress = 1'b1;
        o_ras = 4'h1 << bank_r;
        o_cas = refill_word ? 4'hF : 4'h0;
        o_read_data_enable_out = refill_word;
        o_data_latch_enable = refill_word;
        o_mem_ack = (cnt_r == RF_ACK);
      end
      DRS_WRITE: begin
        o_cycle_in_progress = 1'b1;
        o_ras = 4'h1 << bank_r;
        o_mem_ack = (cnt_r == WR_ACK);
        o_cas = (cnt_r == WR_CAS) ? 4'hF : 4'h0;
      end
      DRS_PWRITE: begin
        o_cycle_in_progress = 1'b1;
        o_ras = 4'h1 << bank_r;
        o_mem_ack = (cnt_r == PW_ACK);
        o_cas = (cnt_r == PW_CAS) ? 4'hF : 4'h0;
      end
      DRS_REFRESH: begin
        // Counts 0 to 2 leave the rows low, which doubles as row precharge.
        o_cas = (cnt_r >= REF_CAS_ON && cnt_r <= REF_CAS_OFF) ? 4'hF : 4'h0;
        o_ras = (cnt_r >= REF_RAS_ON && cnt_r <= REF_RAS_OFF) ? 4'hF : 4'h0;
      end
      default: o_ras = 4'h0;
    endcase
  end

  assign o_page_open_flag = page_open_r;
  assign o_refresh_ack = ref_ack_r;
  assign o_reset_in_progress = rip_r;

  a_ref_ack_next: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ref_pulse |=> (o_refresh_ack && ref_timer_r == REF_TIMER_RST)[*2])
    else $error("Refresh acknowledge missed the edge after the request.");

  a_refresh_first: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (ref_ack_r && (state_r == DRS_IDLE || state_r == DRS_IDLE_RAS)) |=> state_r == DRS_REFRESH)
    else $error("A pending refresh was not the next operation.");

  a_refresh_ten: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(state_r == DRS_REFRESH) |-> (state_r == DRS_REFRESH)[*8]
      ##1 (state_r == DRS_REFRESH) ##1 (state_r == DRS_REFRESH) ##1 (state_r != DRS_REFRESH))
    else $error("Refresh did not last ten cycles.");

  a_cbr_order: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_r == DRS_REFRESH && $rose(o_cas == 4'hF)) |-> (o_ras == 4'h0) ##1 (o_ras == 4'hF))
    else $error("Row strobes did not follow column strobes by one clock.");

  a_read_timing: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(state_r == DRS_READ) |-> (o_ras != 4'h0) && o_cycle_in_progress
      ##2 (o_cas == 4'hF) && o_mem_ack && o_read_data_enable_out)
    else $error("Single read strobes not two clocks after row strobe.");

  a_refill_words: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(state_r == DRS_REFILL) |-> ##2 o_read_data_enable_out ##1 !o_read_data_enable_out
      ##1 o_read_data_enable_out ##1 !o_read_data_enable_out ##1 o_read_data_enable_out
      ##1 !o_read_data_enable_out ##1 o_read_data_enable_out ##1 (state_r == DRS_IDLE))
    else $error("Refill words not paced at one per two clocks.");

  a_refill_ack: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(state_r == DRS_REFILL) |-> !o_mem_ack[*5] ##1 o_mem_ack ##1 !o_mem_ack)
    else $error("Refill acknowledge not between second and third words.");

  a_refill_row: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_r == DRS_REFILL) |-> (o_ras != 4'h0) && (o_data_latch_enable == o_read_data_enable_out))
    else $error("Row strobe dropped or latch enable mismatched during refill.");

  a_precharge_two: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(state_r == DRS_PRECHG) |-> (o_ras == 4'h0 && o_page_open_flag)[*2]
      ##1 (o_ras != 4'h0))
    else $error("Delayed access precharge was not two clocks.");

  a_cip_bound: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(o_cycle_in_progress) |-> ##[1:14] !o_cycle_in_progress)
    else $error("Cycle in progress held beyond fourteen clocks.");

  a_delayed_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (seq_end && (state_r == DRS_READ || state_r == DRS_REFILL))
      |=> !o_page_open_flag && !o_cycle_in_progress && state_r == DRS_IDLE)
    else $error("Read end did not clear page flag and cycle.");

  a_idle_quiet: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_r == DRS_IDLE) |-> (cnt_r == CNT_RST) && (o_ras == 4'h0) && (o_cas == 4'h0)
      && !o_mem_ack && !o_cycle_in_progress)
    else $error("Idle state drove outputs or ran the counter.");

  a_rip_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $fell(o_reset_in_progress) |-> (state_r == DRS_IDLE) && $past(state_r) == DRS_REFRESH)
    else $error("Reset flag cleared without a completed refresh.");

  a_outside_drop: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_r == DRS_IDLE_RAS && !ref_ack_r && blank_r == BLANK_RST && (rd || wr) && space_hi)
      |=> (o_ras == 4'h0) && (state_r == DRS_IDLE))
    else $error("Outside access did not close the held row.");

  a_fifo_no_overflow: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    le_d2_r |-> fifo_ready)
    else $error("Read word arrived with the buffer full.");

  c_refill: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(state_r == DRS_REFILL));
  c_delayed_refill: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    state_r == DRS_PRECHG && pend_r == DRS_REFILL ##2 state_r == DRS_REFILL);
  c_page_write: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(state_r == DRS_PWRITE));
  c_refresh_held: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    ref_ack_r && o_cycle_in_progress ##[1:14] state_r == DRS_REFRESH);
endmodule
`default_nettype wire

// ==== logic/README_unused.sv ====
`default_nettype none
`default_nettype wire

// ==== bench/drs_dram_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module drs_dram_model
  import drs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic [3:0] i_ras,
  input wire logic [3:0] i_cas,
  output logic [DATA_W-1:0] o_dram_data
);
  localparam logic [29:0] WORD_HI = 30'h2A5A_5A5A;
  logic [1:0] addr_r;
  logic cas_d_r;
  logic [DATA_W-1:0] last_r;
  // The processor steps the word address half a cycle after each column strobe ends.
  always_ff @(negedge i_clk_sys) begin
    if (i_ras == 4'h0) begin
      addr_r <= 2'h0;
    end else if (cas_d_r && i_cas == 4'h0) begin
      addr_r <= addr_r + 2'h1;
    end
  end
  // Remember the strobe and the last value seen on the data lines.
  always_ff @(posedge i_clk_sys) begin
    cas_d_r <= (i_cas != 4'h0);
    last_r <= o_dram_data;
  end
  // Outside a column strobe the lines float, so they change every cycle.
  assign o_dram_data = (i_cas != 4'h0) ? {WORD_HI, addr_r} : ~last_r;
endmodule
`default_nettype wire

// ==== bench/dram_read_refresh_sequencer_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module dram_read_refresh_sequencer_tb_top;
  import drs_pkg::*;
  typedef struct {
    logic rd, wr, bu, sp, nr;
    int acks, rdn, at_ack, lat, pre;
    logic pf;
  } drs_row_t;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, bu = 1'b0, sp = 1'b0, nr = 1'b0;
  logic crdy = 1'b1, cval, cycle_in_progress, ack, rden, le, pf, rack, reset_in_progress;
  logic [DATA_W-1:0] dram_data, cdat;
  logic [3:0] ras, cas;
  int err_total = 0, cmp_count = 0, cyc = 0, t0 = 0;
  int acks, rdn, at_ack, lat, pre, gap, cipn, lastk, n, cf, rf, rl, ak, nrf;
  // Rows: request, then acks, words, words by ack, latency, precharge, page flag.
  drs_row_t rows[10] = '{'{1, 0, 0, 0, 0, 1, 1, 1, 2, 0, 0}, '{1, 0, 1, 0, 0, 1, 4, 2, 5, 0, 0},
    '{0, 1, 0, 0, 0, 1, 0, 0, 1, 0, 1}, '{0, 1, 0, 0, 1, 1, 0, 0, 0, 0, 1},
    '{1, 0, 0, 0, 0, 1, 1, 1, 4, 2, 0}, '{0, 1, 0, 0, 0, 1, 0, 0, 1, 0, 1},
    '{1, 0, 1, 0, 0, 1, 4, 2, 7, 2, 0}, '{0, 1, 0, 0, 0, 1, 0, 0, 1, 0, 1},
    '{1, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0}, '{1, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0}};
  // Clock and a free cycle count for interval checks.
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  drs_sequencer dut_u (.i_clk_sys(clk), .i_rst(rst), .i_rd(rd), .i_wr(wr), .i_burst(bu),
    .i_dram_space_select_bit(sp), .i_near_write_hint(nr), .i_bank_sel(2'h0),
    .i_dram_data(dram_data), .i_cpu_ready(crdy), .o_cpu_valid(cval), .o_cpu_data(cdat),
    .o_cycle_in_progress(cycle_in_progress), .o_mem_ack(ack), .o_read_data_enable_out(rden),
    .o_data_latch_enable(le), .o_ras(ras), .o_cas(cas), .o_page_open_flag(pf),
    .o_refresh_ack(rack), .o_reset_in_progress(reset_in_progress));
  drs_dram_model mdl_u (.i_clk_sys(clk), .i_ras(ras), .i_cas(cas), .o_dram_data(dram_data));
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, m, got, exp);
    end
  endtask
  // Hold the whole reset, then count the single refresh that must follow its release.
  task automatic do_reset;
    n = 0;
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) #1;
    chk(reset_in_progress, 1, "reset flag");
    chk({cycle_in_progress, ras, cas, ack}, 0, "outputs in reset");
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 40 && reset_in_progress !== 1'b0; k++) begin
      @(posedge clk) #1;
      if (cas === 4'hF) n++;
    end
    chk(reset_in_progress, 0, "reset flag clears");
    chk(n, 5, "refresh after reset");
    // Software stays off the memory for eight refresh periods after reset.
    nrf = 0;
    for (int k = 0; k < 8200 && !(nrf == 40 && rack === 1'b0); k++) begin
      @(posedge clk) #1;
      if (ras === 4'hF) nrf++;
    end
    chk(nrf, 40, "refreshes before first access");
    t0 = cyc;
  endtask
  // One bus request held until acknowledged; pulses are counted over a fixed window.
  task automatic acc(input drs_row_t r);
    logic drop;
    drop = 1'b0;
    {acks, rdn, at_ack, lat, pre, gap, cipn, lastk} = '0;
    @(posedge clk) {rd, wr, bu, sp, nr} <= {r.rd, r.wr, r.bu, r.sp, r.nr};
    for (int k = 0; k < 30; k++) begin
      @(posedge clk) if (drop) {rd, wr, bu, sp, nr} <= 5'h00;
      #1;
      if (rden === 1'b1 && le === 1'b1 && cas === 4'hF) begin
        rdn++;
        if (rdn > 1 && k - lastk != 2) gap++;
        lastk = k;
      end
      if (ack === 1'b1) begin
        acks++;
        at_ack = rdn;
        drop = 1'b1;
      end
      if (cycle_in_progress === 1'b1 && acks == 0) lat++;
      if (cycle_in_progress === 1'b1) cipn++;
      if (cycle_in_progress === 1'b1 && ras === 4'h0 && pf === 1'b1) pre++;
    end
    @(posedge clk) {rd, wr, bu, sp, nr} <= 5'h00;
  endtask
  // Main sequence: table rows, refresh arbitration, buffer limit, a final reset.
  initial begin
    do_reset();
    foreach (rows[i]) begin
      acc(rows[i]);
      chk(acks, rows[i].acks, "acknowledge count");
      chk(rdn, rows[i].rdn, "words delivered");
      chk(gap, 0, "word spacing");
      chk(at_ack, rows[i].at_ack, "words before ack");
      chk(lat, rows[i].lat, "ack latency");
      chk(pre, rows[i].pre, "precharge");
      chk(pf, rows[i].pf, "page flag");
      chk(ras != 4'h0, rows[i].pf, "row at end");
      chk(cipn <= 14, 1, "cycle length");
    end
    for (int k = 0; k < 1200 && rack !== 1'b1; k++) @(posedge clk) #1;
    chk(rack, 1, "refresh request");
    chk((cyc - t0) inside {[958:964]}, 1, "refresh interval");
    {cf, rf, rl, ak, nrf} = {-32'sd1, -32'sd1, -32'sd1, -32'sd1, 32'sd0};
    @(posedge clk) rd <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(posedge clk) if (ak >= 0) rd <= 1'b0;
      #1;
      if (cas === 4'hF && cf < 0) cf = k;
      if (ras === 4'hF) begin
        nrf++;
        rl = k;
        if (rf < 0) rf = k;
      end
      if (ack === 1'b1 && ak < 0) ak = k;
    end
    chk(rf - cf, 1, "column before row");
    chk(nrf, 5, "refresh row cycles");
    chk(ak > rl, 1, "read waits for refresh");
    chk(rack, 0, "refresh ack drops");
    @(posedge clk) crdy <= 1'b0;
    for (int j = 0; j < 8; j++) begin
      acc(rows[1]);
      chk(acks, j < 7, "buffer room");
    end
    n = 0;
    @(posedge clk) crdy <= 1'b1;
    // Each head word is looked at before the edge that pops it.
    for (int k = 0; k < 60; k++) begin
      #1;
      if (cval === 1'b1) begin
        chk(cdat, {30'h2A5A_5A5A, n[1:0]}, "word order");
        n++;
      end
      @(posedge clk);
    end
    chk(n, 28, "words buffered");
    do_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
